//--- omg_output_mixer_gain_regs.sv
// Output mixer gain register bank with decoded attenuation selects
//
// Behaviour
// - Field MSB ignored; low bits pick 0/-3/-6/-9 dB
// - 0x2F[11:9] second-left positive to left mixer
// - 0x2F[8:6] second-left negative to left mixer
// - 0x2F[5:3] right first amp to left mixer
// - 0x2F[2:0] left first amp to left mixer
// - 0x30[11:9] second-right positive to right mixer
// - 0x30[8:6] second-right negative to right mixer
// - 0x30[5:3] left first amp to right mixer
// - 0x30[2:0] right first amp to right mixer
// - 0x31[11:9] left converter to left mixer
// - 0x31[8:6] second-right negative to left mixer
// - 0x31[5:3] right bypass to left mixer
// - 0x31[2:0] left bypass to left mixer
// - 0x32[11:9] right converter to right mixer
// - 0x32[8:6] second-left negative to right mixer
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "omg_regs.svh"

module omg_output_mixer_gain_regs
  import omg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Analog mixer gain selects
  output omg_gain_bus_s gain_sel
);

  omg_state_s state_r;
  omg_state_s state_nxt;
  omg_req_s req;
  logic [3:0] wr_hit;
  logic [3:0] rd_hit;

  // Only the two low bits reach the gain stage, so X00 and 100 both mean 0 dB
  function automatic omg_atten_e omg_decode(input logic [15:0] regv, input int lsb);
    logic [1:0] code;
    omg_atten_e sel;
    code = regv[lsb +: 2];
    case (code)
      2'h0: begin
        sel = OMG_ATT_0DB;
      end
      2'h1: begin
        sel = OMG_ATT_3DB;
      end
      2'h2: begin
        sel = OMG_ATT_6DB;
      end
      default: begin
        sel = OMG_ATT_9DB;
      end
    endcase
    omg_decode = sel;
  endfunction : omg_decode

  // Shared by the write and read paths so the two can never disagree on the map
  function automatic logic [3:0] omg_hit(input logic [7:0] addr);
    logic [3:0] hit;
    hit = 4'h0;
    case (addr)
      `OMG_LEFT_GAIN_A_OFS: begin
        hit = 4'h1;
      end
      `OMG_RIGHT_GAIN_A_OFS: begin
        hit = 4'h2;
      end
      `OMG_LEFT_GAIN_B_OFS: begin
        hit = 4'h4;
      end
      `OMG_RIGHT_GAIN_B_OFS: begin
        hit = 4'h8;
      end
      default: begin
        hit = 4'h0;
      end
    endcase
    omg_hit = hit;
  endfunction : omg_hit

  // Replaces one 3-bit field and leaves the rest of the word alone
  function automatic logic [15:0] omg_put(input logic [15:0] word, input logic [15:0] src, input int lsb);
    logic [15:0] res;
    res = word;
    res[lsb +: 3] = src[lsb +: 3];
    omg_put = res;
  endfunction : omg_put

  // Bits a register really stores; the low fields of the last word belong elsewhere
  function automatic logic [15:0] omg_keep(input logic [3:0] hit);
    logic [15:0] mask;
    mask = 16'h0000;
    case (hit)
      4'h1: begin
        mask = `OMG_FULL_MASK;
      end
      4'h2: begin
        mask = `OMG_FULL_MASK;
      end
      4'h4: begin
        mask = `OMG_FULL_MASK;
      end
      4'h8: begin
        mask = `OMG_UPPER_MASK;
      end
      default: begin
        mask = 16'h0000;
      end
    endcase
    omg_keep = mask;
  endfunction : omg_keep

  // Read mux; a miss returns zero rather than a stale word
  function automatic logic [15:0] omg_readback(input omg_state_s st, input logic [3:0] hit);
    logic [15:0] word;
    word = 16'h0000;
    case (hit)
      4'h1: begin
        word = st.left_outmix_input_gain_a;
      end
      4'h2: begin
        word = st.right_outmix_input_gain_a;
      end
      4'h4: begin
        word = st.left_outmix_input_gain_b;
      end
      4'h8: begin
        word = st.right_outmix_input_gain_b;
      end
      default: begin
        word = 16'h0000;
      end
    endcase
    omg_readback = word;
  endfunction : omg_readback

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  assign wr_hit = req.wr ? omg_hit(req.addr) : 4'h0;
  assign rd_hit = req.rd ? omg_hit(req.addr) : 4'h0;

  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = 16'h0000;
    // Writes keep the full 3-bit fields so software reads back what it wrote
    if (wr_hit[0]) begin
      state_nxt.left_outmix_input_gain_a =
        omg_put(state_nxt.left_outmix_input_gain_a, req.wdata, `OMG_FLD3_LSB);
      state_nxt.left_outmix_input_gain_a =
        omg_put(state_nxt.left_outmix_input_gain_a, req.wdata, `OMG_FLD2_LSB);
      state_nxt.left_outmix_input_gain_a =
        omg_put(state_nxt.left_outmix_input_gain_a, req.wdata, `OMG_FLD1_LSB);
      state_nxt.left_outmix_input_gain_a =
        omg_put(state_nxt.left_outmix_input_gain_a, req.wdata, `OMG_FLD0_LSB);
      state_nxt.left_outmix_input_gain_a =
        state_nxt.left_outmix_input_gain_a & omg_keep(wr_hit);
    end
    if (wr_hit[1]) begin
      state_nxt.right_outmix_input_gain_a =
        omg_put(state_nxt.right_outmix_input_gain_a, req.wdata, `OMG_FLD3_LSB);
      state_nxt.right_outmix_input_gain_a =
        omg_put(state_nxt.right_outmix_input_gain_a, req.wdata, `OMG_FLD2_LSB);
      state_nxt.right_outmix_input_gain_a =
        omg_put(state_nxt.right_outmix_input_gain_a, req.wdata, `OMG_FLD1_LSB);
      state_nxt.right_outmix_input_gain_a =
        omg_put(state_nxt.right_outmix_input_gain_a, req.wdata, `OMG_FLD0_LSB);
      state_nxt.right_outmix_input_gain_a =
        state_nxt.right_outmix_input_gain_a & omg_keep(wr_hit);
    end
    if (wr_hit[2]) begin
      state_nxt.left_outmix_input_gain_b =
        omg_put(state_nxt.left_outmix_input_gain_b, req.wdata, `OMG_FLD3_LSB);
      state_nxt.left_outmix_input_gain_b =
        omg_put(state_nxt.left_outmix_input_gain_b, req.wdata, `OMG_FLD2_LSB);
      state_nxt.left_outmix_input_gain_b =
        omg_put(state_nxt.left_outmix_input_gain_b, req.wdata, `OMG_FLD1_LSB);
      state_nxt.left_outmix_input_gain_b =
        omg_put(state_nxt.left_outmix_input_gain_b, req.wdata, `OMG_FLD0_LSB);
      state_nxt.left_outmix_input_gain_b =
        state_nxt.left_outmix_input_gain_b & omg_keep(wr_hit);
    end
    // Only the two upper fields live here; the rest of this word stays zero
    if (wr_hit[3]) begin
      state_nxt.right_outmix_input_gain_b =
        omg_put(state_nxt.right_outmix_input_gain_b, req.wdata, `OMG_FLD3_LSB);
      state_nxt.right_outmix_input_gain_b =
        omg_put(state_nxt.right_outmix_input_gain_b, req.wdata, `OMG_FLD2_LSB);
      state_nxt.right_outmix_input_gain_b =
        state_nxt.right_outmix_input_gain_b & omg_keep(wr_hit);
    end
    // Unmapped addresses and idle cycles read as zero
    if (req.rd) begin
      state_nxt.rdata = omg_readback(state_r, rd_hit);
    end
    // Decoded from the next values so the selects settle in the same edge as the store
    state_nxt.gain.second_left_pos_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_a, `OMG_FLD3_LSB);
    state_nxt.gain.second_left_neg_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_a, `OMG_FLD2_LSB);
    state_nxt.gain.first_right_amp_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_a, `OMG_FLD1_LSB);
    state_nxt.gain.first_left_amp_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_a, `OMG_FLD0_LSB);
    state_nxt.gain.second_right_pos_to_right_outmix_gain =
      omg_decode(state_nxt.right_outmix_input_gain_a, `OMG_FLD3_LSB);
    state_nxt.gain.second_right_neg_to_right_outmix_gain =
      omg_decode(state_nxt.right_outmix_input_gain_a, `OMG_FLD2_LSB);
    state_nxt.gain.first_left_amp_to_right_outmix_gain =
      omg_decode(state_nxt.right_outmix_input_gain_a, `OMG_FLD1_LSB);
    state_nxt.gain.first_right_amp_to_right_outmix_gain =
      omg_decode(state_nxt.right_outmix_input_gain_a, `OMG_FLD0_LSB);
    state_nxt.gain.left_converter_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_b, `OMG_FLD3_LSB);
    state_nxt.gain.second_right_neg_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_b, `OMG_FLD2_LSB);
    state_nxt.gain.right_bypass_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_b, `OMG_FLD1_LSB);
    state_nxt.gain.left_bypass_to_left_outmix_gain =
      omg_decode(state_nxt.left_outmix_input_gain_b, `OMG_FLD0_LSB);
    state_nxt.gain.right_converter_to_right_outmix_gain =
      omg_decode(state_nxt.right_outmix_input_gain_b, `OMG_FLD3_LSB);
    state_nxt.gain.second_left_neg_to_right_outmix_gain =
      omg_decode(state_nxt.right_outmix_input_gain_b, `OMG_FLD2_LSB);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r.left_outmix_input_gain_a <= `OMG_LEFT_GAIN_A_RST;
      state_r.right_outmix_input_gain_a <= `OMG_RIGHT_GAIN_A_RST;
      state_r.left_outmix_input_gain_b <= `OMG_LEFT_GAIN_B_RST;
      state_r.right_outmix_input_gain_b <= `OMG_RIGHT_GAIN_B_RST;
      state_r.rdata <= 16'h0000;
      state_r.gain.second_left_pos_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.second_left_neg_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.first_right_amp_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.first_left_amp_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.second_right_pos_to_right_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.second_right_neg_to_right_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.first_left_amp_to_right_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.first_right_amp_to_right_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.left_converter_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.second_right_neg_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.right_bypass_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.left_bypass_to_left_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.right_converter_to_right_outmix_gain <= OMG_ATT_0DB;
      state_r.gain.second_left_neg_to_right_outmix_gain <= OMG_ATT_0DB;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign gain_sel = state_r.gain;

endmodule : omg_output_mixer_gain_regs

//--- omg_output_mixer_gain_regs_tb.sv
// Mixer gain bank bench
`timescale 1ns/100ps
module omg_output_mixer_gain_regs_tb import omg_pkg::*; ;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, m [4] = '{4{16'h0000}}, rq [$];
  omg_gain_bus_s gain_sel;
  omg_gain_bus_s gq [$];
  logic wr_d = 1'b0;
  int err_count = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  omg_output_mixer_gain_regs i_omg_output_mixer_gain_regs (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_sel(gain_sel));
  // Expected one-hot select of field f of a stored word; top field bit is ignored
  function automatic logic [3:0] g1(input logic [15:0] v, input int f);
    return 4'h1 << v[f*3+:2];
  endfunction : g1
  function automatic omg_gain_bus_s eg();
    return {g1(m[0], 3), g1(m[0], 2), g1(m[0], 1), g1(m[0], 0), g1(m[1], 3), g1(m[1], 2), g1(m[1], 1),
      g1(m[1], 0), g1(m[2], 3), g1(m[2], 2), g1(m[2], 1), g1(m[2], 0), g1(m[3], 3), g1(m[3], 2)};
  endfunction : eg
  task automatic acc(input logic w, logic [7:0] ad, logic [15:0] d);
    @(posedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, ad, d};
    if (w && ad > 8'h2e && ad < 8'h33) m[ad-8'h2f] = d & (ad == 8'h32 ? 16'h0fc0 : 16'h0fff);
    if (!w) rq.push_back(ad > 8'h2e && ad < 8'h33 ? m[ad-8'h2f] : 16'h0000);
    if (w) gq.push_back(eg());
  endtask : acc
  task automatic chk_g(input omg_gain_bus_s e, g);
    checks_done++;
    err_count += int'(g !== e);
    if (g !== e) $display("[FAIL] %0t gain %h exp %h", $time, g, e);
  endtask : chk_g
  task automatic chk_r(input logic [15:0] e, g);
    checks_done++;
    err_count += int'(g !== e);
    if (g !== e) $display("[FAIL] %0t rdata %h exp %h", $time, g, e);
  endtask : chk_r
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(negedge clk) begin
    if (rd_d) chk_r(rq.pop_front(), reg_rdata);
    rd_d = reg_rd;
    if (wr_d) chk_g(gq.pop_front(), gain_sel);
    wr_d = reg_wr;
    cyc++;
    if (cyc > 400) err_count++;
    if (cyc > 400) end_sim();
  end
  initial begin
    void'($urandom(47083));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) acc(1'b0, 8'h2c + 8'(i), 16'h0000);
    for (int i = 0; i < 64; i++) acc(i % 2 == 0, 8'h2f + 8'(i / 2 % 4), {4'($urandom), {4{3'(i / 8)}}});
    for (int i = 0; i < 60; i++) acc(1'($urandom), 8'h2c + 8'($urandom % 8), 16'($urandom));
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : omg_output_mixer_gain_regs_tb

//--- omg_pkg.sv
// Types shared by the output mixer gain register bank
package omg_pkg;

  // One-hot attenuation select for one analog gain stage
  typedef enum logic [3:0] {
    OMG_ATT_0DB = 4'h1,
    OMG_ATT_3DB = 4'h2,
    OMG_ATT_6DB = 4'h4,
    OMG_ATT_9DB = 4'h8
  } omg_atten_e;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } omg_req_s;

  // Decoded selects toward the analog mixers
  typedef struct packed {
    omg_atten_e second_left_pos_to_left_outmix_gain;
    omg_atten_e second_left_neg_to_left_outmix_gain;
    omg_atten_e first_right_amp_to_left_outmix_gain;
    omg_atten_e first_left_amp_to_left_outmix_gain;
    omg_atten_e second_right_pos_to_right_outmix_gain;
    omg_atten_e second_right_neg_to_right_outmix_gain;
    omg_atten_e first_left_amp_to_right_outmix_gain;
    omg_atten_e first_right_amp_to_right_outmix_gain;
    omg_atten_e left_converter_to_left_outmix_gain;
    omg_atten_e second_right_neg_to_left_outmix_gain;
    omg_atten_e right_bypass_to_left_outmix_gain;
    omg_atten_e left_bypass_to_left_outmix_gain;
    omg_atten_e right_converter_to_right_outmix_gain;
    omg_atten_e second_left_neg_to_right_outmix_gain;
  } omg_gain_bus_s;

  // All state of the bank
  typedef struct packed {
    logic [15:0] left_outmix_input_gain_a;
    logic [15:0] right_outmix_input_gain_a;
    logic [15:0] left_outmix_input_gain_b;
    logic [15:0] right_outmix_input_gain_b;
    logic [15:0] rdata;
    omg_gain_bus_s gain;
  } omg_state_s;

endpackage : omg_pkg

//--- omg_regs.svh
// Offsets, field positions, masks and reset values of the output mixer gain registers
`ifndef OMG_REGS_SVH
`define OMG_REGS_SVH

`define OMG_ADDR_W 8
`define OMG_DATA_W 16

`define OMG_LEFT_GAIN_A_OFS 8'h2f
`define OMG_RIGHT_GAIN_A_OFS 8'h30
`define OMG_LEFT_GAIN_B_OFS 8'h31
`define OMG_RIGHT_GAIN_B_OFS 8'h32

`define OMG_LEFT_GAIN_A_RST 16'h0000
`define OMG_RIGHT_GAIN_A_RST 16'h0000
`define OMG_LEFT_GAIN_B_RST 16'h0000
`define OMG_RIGHT_GAIN_B_RST 16'h0000

`define OMG_FULL_MASK 16'h0fff
`define OMG_UPPER_MASK 16'h0fc0

`define OMG_FLD3_LSB 9
`define OMG_FLD2_LSB 6
`define OMG_FLD1_LSB 3
`define OMG_FLD0_LSB 0

`endif

//--- omg_regs_checker.sv
// Mixer gain bank assertions
`timescale 1ns/100ps
module omg_regs_checker
  import omg_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Bus and gains
  input logic [7:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  input omg_gain_bus_s gain_sel
);
  // Top field bit ignored
  function automatic logic [15:0] dec4(input logic [15:0] v);
    for (int i = 0; i < 4; i++) dec4[i*4+:4] = 4'h1 << v[i*3+:2];
  endfunction : dec4
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_WR_2F: assert property (reg_wr && reg_addr == 8'h2f |=> gain_sel[55:40] == dec4($past(reg_wdata)))
    else $error("gain 2f");
  AST_WR_30: assert property (reg_wr && reg_addr == 8'h30 |=> gain_sel[39:24] == dec4($past(reg_wdata)))
    else $error("gain 30");
  AST_WR_31: assert property (reg_wr && reg_addr == 8'h31 |=> gain_sel[23:8] == dec4($past(reg_wdata)))
    else $error("gain 31");
  AST_WR_32: assert property (reg_wr && reg_addr == 8'h32 |=> gain_sel[7:0] == 8'(dec4($past(reg_wdata) >> 6)))
    else $error("gain 32");
  AST_RB_31: assert property (reg_wr && reg_addr == 8'h31 ##1 reg_rd && reg_addr == 8'h31 |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h0fff)) else $error("readback");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("rdata idle");
  AST_GAIN_HOLD: assert property (!$past(reg_wr) |-> $stable(gain_sel))
    else $error("gain moved");
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> gain_sel == {14{4'h1}})
    else $error("reset gain");
endmodule : omg_regs_checker
bind omg_output_mixer_gain_regs omg_regs_checker i_omg_regs_checker (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .gain_sel(gain_sel));
